//--- hw/tsm_pkg.sv
package tsm_pkg;
  localparam int COND_N  = 4;
  localparam int STATE_W = 2;
  localparam int CNT_W   = 8;
  localparam int EXT_N   = 8;
  localparam int EXT_W   = 3;
  localparam int XT_N    = 4;
  localparam int SIG_W   = 8;
  localparam int BP_N    = 4;
  localparam int ADDR_W  = COND_N + 3 + STATE_W;
  localparam int WORD_W  = STATE_W + 3 + CNT_W;
  localparam int DEPTH   = 1 << ADDR_W;

  localparam int A_EXT = COND_N;
  localparam int A_XT  = COND_N + 1;
  localparam int A_CZ  = COND_N + 2;
  localparam int A_ST  = COND_N + 3;

  localparam int W_NS    = 0;
  localparam int W_TRIG  = STATE_W;
  localparam int W_CNTEN = STATE_W + 1;
  localparam int W_CNTLD = STATE_W + 2;
  localparam int W_CVAL  = STATE_W + 3;

  localparam logic BUF_DIST    = 1'h0;
  localparam logic BUFFER_TYPE = BUF_DIST;

  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_STATUS = 8'h04;
  localparam logic [7:0] R_TADDR  = 8'h08;
  localparam logic [7:0] R_TDATA  = 8'h0C;
  localparam logic [7:0] R_XSEL   = 8'h10;
  localparam logic [7:0] R_COND0  = 8'h20;

  localparam int C_START = 0;
  localparam int C_STOP  = 1;
  localparam int C_CLEAR = 2;
  localparam int S_RUN   = 0;
  localparam int S_TRIG  = 1;
  localparam int S_CLR   = 2;
  localparam int S_CZ    = 3;
  localparam int S_ST    = 4;
  localparam int S_CNT   = 8;
  localparam int X_EXT   = 0;
  localparam int X_MASK  = 8;
  localparam int CD_VAL  = 0;
  localparam int CD_CARE = 8;
  localparam int CD_BP   = 16;

  localparam logic [31:0] XSEL_RST = 32'h0000_0000;
  localparam logic [31:0] COND_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TSM_IDLE  = 2'b00,
    TSM_RUN   = 2'b01,
    TSM_CLEAR = 2'b10
  } tsm_mode_e;
endpackage

//--- hw/tsm_cond.sv
`timescale 1ns/1ps
module tsm_cond (
  input  wire logic [tsm_pkg::SIG_W-1:0] sig_i,
  input  wire logic [tsm_pkg::SIG_W-1:0] cmp_i,
  input  wire logic [tsm_pkg::SIG_W-1:0] care_i,
  input  wire logic [tsm_pkg::BP_N-1:0]  bp_i,
  input  wire logic [tsm_pkg::BP_N-1:0]  bp_en_i,
  output logic                           hit_o
);
  wire sig_match;
  wire bp_any;

  // one result bit
  // All cared signals must match, and any enabled breakpoint qualifies.
  // With no breakpoint enabled the breakpoint term is treated as true.
  assign sig_match = ((sig_i ^ cmp_i) & care_i) == '0;
  assign bp_any    = (bp_en_i == '0) || (|(bp_i & bp_en_i));
  assign hit_o     = sig_match & bp_any;
endmodule

//--- hw/tsm_table.sv
`timescale 1ns/1ps
module tsm_table #(
  parameter logic BUF_TYPE = tsm_pkg::BUFFER_TYPE
) (
  input  wire logic                        clk_i,
  input  wire logic                        we_i,
  input  wire logic [tsm_pkg::ADDR_W-1:0]  waddr_i,
  input  wire logic [tsm_pkg::WORD_W-1:0]  wdata_i,
  input  wire logic [tsm_pkg::ADDR_W-1:0]  laddr_i,
  input  wire logic [tsm_pkg::ADDR_W-1:0]  raddr_i,
  output logic      [tsm_pkg::WORD_W-1:0]  lword_o,
  output logic      [tsm_pkg::WORD_W-1:0]  rword_o
);
  // The buffer type is shared with the sample buffer; only the distributed
  // style is offered because the lookup must answer within the same cycle.
  logic [tsm_pkg::WORD_W-1:0] mem [tsm_pkg::DEPTH];

  generate
    if (BUF_TYPE == tsm_pkg::BUF_DIST)
    begin : g_dist
      always_ff @(posedge clk_i)
      begin
        if (we_i)
          mem[waddr_i] <= wdata_i;
      end
      assign lword_o = mem[laddr_i];
      assign rword_o = mem[raddr_i];
    end
  endgenerate
endmodule

//--- hw/tsm_top.sv
`timescale 1ns/1ps
module tsm_top (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [tsm_pkg::SIG_W-1:0]     sig_i,
  input  wire logic [tsm_pkg::BP_N-1:0]      bp_i,
  input  wire logic [tsm_pkg::EXT_N-1:0]     external_trigger_input_i,
  input  wire logic [tsm_pkg::XT_N-1:0]      source_unit_triggered_i,
  output logic                               trigger_o,
  output logic                               running_o
);
  localparam int CN = tsm_pkg::COND_N;
  localparam int SW = tsm_pkg::STATE_W;
  localparam int CW = tsm_pkg::CNT_W;
  localparam int AW = tsm_pkg::ADDR_W;
  localparam int WW = tsm_pkg::WORD_W;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [3:0] sel,
                                        input logic [31:0] new_v);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  tsm_pkg::tsm_mode_e mode_r;
  logic [SW-1:0]                 state_r;
  logic [CW-1:0]                 cnt_r;
  logic                          trig_r;
  logic                          seen_r;
  logic [AW-1:0]                 taddr_r;
  logic [AW-1:0]                 sweep_r;
  logic                          ack_r;
  logic [31:0]                   dat_r;
  logic [31:0]                   xsel_r;
  logic [31:0]                   cond_r [CN];
  logic [tsm_pkg::EXT_N-1:0]     ext_s1_r;
  logic [tsm_pkg::EXT_N-1:0]     ext_s2_r;
  logic [tsm_pkg::XT_N-1:0]      xt_s1_r;
  logic [tsm_pkg::XT_N-1:0]      xt_s2_r;
  logic [CN-1:0]                 hits;
  logic [WW-1:0]                 lword;
  logic [WW-1:0]                 rword;

  wire            bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire            bus_wr   = bus_req & wb_we_i;
  wire            ctrl_wr  = bus_wr & (wb_adr_i == tsm_pkg::R_CTRL) & wb_sel_i[0];
  wire            start_wr = ctrl_wr & wb_dat_i[tsm_pkg::C_START];
  wire            stop_wr  = ctrl_wr & wb_dat_i[tsm_pkg::C_STOP];
  wire            clr_wr   = ctrl_wr & wb_dat_i[tsm_pkg::C_CLEAR];
  wire            taddr_wr = bus_wr & (wb_adr_i == tsm_pkg::R_TADDR);
  wire            tdata_wr = bus_wr & (wb_adr_i == tsm_pkg::R_TDATA);
  wire            xsel_wr  = bus_wr & (wb_adr_i == tsm_pkg::R_XSEL);
  wire            cond_hit = wb_adr_i[7:4] == tsm_pkg::R_COND0[7:4];
  wire [1:0]      cond_idx = wb_adr_i[3:2];
  wire            run      = mode_r == tsm_pkg::TSM_RUN;
  wire            clearing = mode_r == tsm_pkg::TSM_CLEAR;
  wire            ctl_evt  = start_wr | stop_wr | clr_wr;

  wire [2:0]      ext_sel  = xsel_r[tsm_pkg::X_EXT +: tsm_pkg::EXT_W];
  wire [3:0]      xt_mask  = xsel_r[tsm_pkg::X_MASK +: tsm_pkg::XT_N];

  wire            cnt_zero = cnt_r == '0;
  wire            ext_bit  = ext_s2_r[ext_sel];
  wire            xt_bit   = (xt_mask != '0) && ((xt_s2_r & xt_mask) == xt_mask);
  wire [AW-1:0]   laddr    = {state_r, cnt_zero, xt_bit, ext_bit, hits};

  wire [SW-1:0]   lw_ns    = lword[tsm_pkg::W_NS +: SW];
  wire            lw_trig  = lword[tsm_pkg::W_TRIG];
  wire            lw_cnten = lword[tsm_pkg::W_CNTEN];
  wire            lw_cntld = lword[tsm_pkg::W_CNTLD];
  wire [CW-1:0]   lw_cval  = lword[tsm_pkg::W_CVAL +: CW];

  wire [WW-1:0]   def_word = {{(WW - SW){1'b0}}, sweep_r[tsm_pkg::A_ST +: SW]};
  wire [31:0]     tw_old   = {{(32 - WW){1'b0}}, rword};
  wire [31:0]     tw_new   = merge(tw_old, wb_sel_i, wb_dat_i);
  // A clear sweep owns the write port, so table writes during it are dropped.
  wire            tbl_we   = clearing | tdata_wr;
  wire [AW-1:0]   tbl_wa   = clearing ? sweep_r : taddr_r;
  wire [WW-1:0]   tbl_wd   = clearing ? def_word : tw_new[WW-1:0];

  wire [31:0]     status   = {16'h0000, cnt_r, 2'h0, state_r, cnt_zero, clearing, seen_r, run};
  wire [31:0]     taddr32  = {{(32 - AW){1'b0}}, taddr_r};
  wire [31:0]     rd_val   = (wb_adr_i == tsm_pkg::R_CTRL)   ? 32'h0000_0000 :
                             (wb_adr_i == tsm_pkg::R_STATUS) ? status :
                             (wb_adr_i == tsm_pkg::R_TADDR)  ? taddr32 :
                             (wb_adr_i == tsm_pkg::R_TDATA)  ? tw_old :
                             (wb_adr_i == tsm_pkg::R_XSEL)   ? xsel_r :
                             cond_hit                        ? cond_r[cond_idx] :
                             32'h0000_0000;

  genvar gi;
  generate
    for (gi = 0; gi < CN; gi++)
    begin : g_cond
      tsm_cond u_cond (
        .sig_i   (sig_i),
        .cmp_i   (cond_r[gi][tsm_pkg::CD_VAL +: tsm_pkg::SIG_W]),
        .care_i  (cond_r[gi][tsm_pkg::CD_CARE +: tsm_pkg::SIG_W]),
        .bp_i    (bp_i),
        .bp_en_i (cond_r[gi][tsm_pkg::CD_BP +: tsm_pkg::BP_N]),
        .hit_o   (hits[gi])
      );
    end
  endgenerate

  tsm_table u_table (
    .clk_i   (clk_i),
    .we_i    (tbl_we),
    .waddr_i (tbl_wa),
    .wdata_i (tbl_wd),
    .laddr_i (laddr),
    .raddr_i (taddr_r),
    .lword_o (lword),
    .rword_o (rword)
  );

  // External and cross-trigger inputs come from other domains.
  always_ff @(posedge clk_i)
  begin
    ext_s1_r <= external_trigger_input_i;
    ext_s2_r <= ext_s1_r;
    xt_s1_r  <= source_unit_triggered_i;
    xt_s2_r  <= xt_s1_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h0000_0000;
      xsel_r <= tsm_pkg::XSEL_RST;
      for (int i = 0; i < CN; i++)
        cond_r[i] <= tsm_pkg::COND_RST;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req)
        dat_r <= wb_we_i ? 32'h0000_0000 : rd_val;
      if (xsel_wr)
        xsel_r <= merge(xsel_r, wb_sel_i, wb_dat_i);
      if (bus_wr && cond_hit)
        cond_r[cond_idx] <= merge(cond_r[cond_idx], wb_sel_i, wb_dat_i);
    end
  end

  // Table pointer auto-increments on each data write outside a clear sweep, for burst loading.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      taddr_r <= '0;
    else if (taddr_wr)
      taddr_r <= AW'(merge(taddr32, wb_sel_i, wb_dat_i));
    else if (tdata_wr && !clearing)
      taddr_r <= taddr_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r  <= tsm_pkg::TSM_CLEAR;
      sweep_r <= '0;
    end
    else if (clr_wr)
    begin
      mode_r  <= tsm_pkg::TSM_CLEAR;
      sweep_r <= '0;
    end
    else
    begin
      case (mode_r)
        tsm_pkg::TSM_IDLE:
          mode_r <= start_wr ? tsm_pkg::TSM_RUN : tsm_pkg::TSM_IDLE;
        tsm_pkg::TSM_RUN:
          mode_r <= stop_wr ? tsm_pkg::TSM_IDLE : tsm_pkg::TSM_RUN;
        tsm_pkg::TSM_CLEAR:
        begin
          sweep_r <= sweep_r + 1'b1;
          if (sweep_r == '1)
            mode_r <= tsm_pkg::TSM_IDLE;
        end
        default:
          mode_r <= tsm_pkg::TSM_IDLE;
      endcase
    end
  end

  // A new trigger in the cycle a run restarts still marks the status bit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= '0;
      cnt_r   <= '0;
      trig_r  <= 1'b0;
      seen_r  <= 1'b0;
    end
    else
    begin
      trig_r <= run & lw_trig & ~ctl_evt;
      seen_r <= (run & lw_trig) | (seen_r & ~start_wr);
      if (start_wr && !clearing)
      begin
        state_r <= '0;
        cnt_r   <= '0;
      end
      else if (run && !ctl_evt)
      begin
        state_r <= lw_ns;
        if (lw_cntld)
          cnt_r <= lw_cval;
        else if (lw_cnten)
          cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign trigger_o = trig_r;
  assign running_o = run;
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_addr_fields: assert property (
    laddr[tsm_pkg::A_ST +: SW] == state_r && laddr[CN-1:0] == hits)
    else $error("lookup address does not carry state and condition bits");
  a_next_state: assert property ((run && !ctl_evt) |=> state_r == $past(lw_ns))
    else $error("state register did not take the table next state");
  a_trig_pulse: assert property (
    (run && lw_trig && !ctl_evt) |=>
      trigger_o ##1 (trigger_o == $past(run && lw_trig && !ctl_evt)))
    else $error("trigger strobe does not follow the table trigger bit");
  a_cnt_dec: assert property (
    (run && !ctl_evt && lw_cnten && !lw_cntld) |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("counter did not decrement by one");
  a_cnt_load: assert property ((run && !ctl_evt && lw_cntld) |=> cnt_r == $past(lw_cval))
    else $error("counter did not take the load value");
  a_cnt_hold: assert property (
    (run && !ctl_evt && !lw_cntld && !lw_cnten) |=> $stable(cnt_r))
    else $error("counter changed without a load or count enable");
  a_start_zero: assert property (
    (start_wr && !stop_wr && !clearing && !clr_wr) |=> run && state_r == '0 && cnt_r == '0)
    else $error("run did not start in state zero with a cleared counter");
  a_zero_flag: assert property (
    (run && !ctl_evt && lw_cntld && lw_cval == '0) |=> laddr[tsm_pkg::A_CZ])
    else $error("counter zero flag missing after loading zero");
  a_ext_select: assert property (laddr[tsm_pkg::A_EXT] == ext_s2_r[ext_sel])
    else $error("external trigger bit not the selected input");
  a_xt_all: assert property (
    (xt_mask != '0 && (xt_s2_r & xt_mask) != xt_mask) |-> !laddr[tsm_pkg::A_XT])
    else $error("cross trigger bit set before all selected sources");
  a_clear_entry: assert property (
    clearing |-> tbl_we && tbl_wd[tsm_pkg::W_NS +: SW] == tbl_wa[tsm_pkg::A_ST +: SW] &&
    tbl_wd[WW-1:SW] == '0)
    else $error("cleared table entry is not a quiet self loop");
  a_idle_quiet: assert property ((!run && !start_wr) |=> !trigger_o && $stable(state_r))
    else $error("state machine moved while not running");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held for more than one cycle");

  c_trigger: cover property (run ##1 trigger_o);
  c_load_count: cover property ((run && lw_cntld) ##[1:20] (run && lw_cnten && cnt_zero == 1'b0));
  c_clear_done: cover property (clearing ##1 (mode_r == tsm_pkg::TSM_IDLE));
  c_cross_trig: cover property (run && xt_bit && lw_trig);
endmodule

//--- verification/tsm_far_end.sv
`timescale 1ns/1ps
module tsm_far_end (
  input  wire logic                 clk_i,
  input  wire logic                 trigger_i,
  output logic [tsm_pkg::SIG_W-1:0] sig_o,
  output logic [tsm_pkg::BP_N-1:0]  bp_o,
  output logic [tsm_pkg::EXT_N-1:0] ext_o,
  output logic [tsm_pkg::XT_N-1:0]  xt_o
);
  int snaps = 0;

  initial
  begin
    sig_o = 8'h5A;
    bp_o  = 4'h0;
    ext_o = 8'h00;
    xt_o  = 4'h0;
  end

  // Breakpoint hits wander every cycle; no breakpoint is enabled, so they must not matter.
  always @(posedge clk_i)
    bp_o <= bp_o + 4'h1;

  always @(posedge clk_i)
    if (trigger_i === 1'b1)
      snaps <= snaps + 1;

  // Idle probe value is the inverse of the match pattern, so a stale value can never match.
  task automatic drive(input logic [7:0] s, input logic [7:0] e, input logic [3:0] x,
                       input int n);
    sig_o <= s;
    ext_o <= e;
    xt_o  <= x;
    repeat (n) @(posedge clk_i);
    sig_o <= 8'h5A;
    ext_o <= 8'h00;
    xt_o  <= 4'h0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic        ack;
  logic        trig;
  logic        run;
  logic [7:0]  sig;
  logic [3:0]  bp;
  logic [7:0]  ext;
  logic [3:0]  xt;
  int          errors  = 0;
  int          n_tests = 0;
  int          s0;
  int          k;

  always #20 clk_i = ~clk_i;

  tsm_top u_tsm_top (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .wb_cyc_i                 (cyc),
    .wb_stb_i                 (stb),
    .wb_we_i                  (we),
    .wb_adr_i                 (adr),
    .wb_sel_i                 (4'hF),
    .wb_dat_i                 (wdat),
    .wb_dat_o                 (dat_o),
    .wb_ack_o                 (ack),
    .sig_i                    (sig),
    .bp_i                     (bp),
    .external_trigger_input_i (ext),
    .source_unit_triggered_i  (xt),
    .trigger_o                (trig),
    .running_o                (run)
  );

  tsm_far_end u_tsm_far_end (
    .clk_i     (clk_i),
    .trigger_i (trig),
    .sig_o     (sig),
    .bp_o      (bp),
    .ext_o     (ext),
    .xt_o      (xt)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      errors++;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask

  // The sweep after reset or CLEAR drops table writes, so nothing is loaded before it ends.
  task automatic wait_clear();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, tsm_pkg::R_STATUS, 32'h0000_0000);
      n++;
    end
    while (rdat[2] !== 1'b0 && n < 400);
    if (rdat[2] !== 1'b0)
      errors++;
  endtask

  task automatic fill(input logic [1:0] st, input int mode);
    logic [12:0] w;
    int a;
    wr(tsm_pkg::R_TADDR, {23'h0, st, 7'h00});
    for (a = 0; a < 128; a++)
    begin
      case (mode)
        0:       w = 13'h131;
        1:       w = a[1] ? (a[6] ? 13'h005 : 13'h009) : 13'h001;
        // Every entry also reloads zero, so the counter-zero flag is driven by a load.
        default: w = {8'h00, 1'b1, 1'b0, a[4] | a[5], 2'b00};
      endcase
      wr(tsm_pkg::R_TDATA, {19'h0, w});
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_clear();
    rd(tsm_pkg::R_CTRL, 32'h0000_0000);
    rd(tsm_pkg::R_XSEL, tsm_pkg::XSEL_RST);
    rd(tsm_pkg::R_COND0 + 8'h04, tsm_pkg::COND_RST);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    wr(tsm_pkg::R_TADDR, 32'hFFFF_FFFF);
    rd(tsm_pkg::R_TADDR, 32'h0000_01FF);
    wr(tsm_pkg::R_COND0 + 8'h04, 32'h0000_FFA5);
    rd(tsm_pkg::R_COND0 + 8'h04, 32'h0000_FFA5);
    $display("end of test registers");

    fill(2'd0, 0);
    fill(2'd1, 1);
    rd(tsm_pkg::R_TADDR, 32'h0000_0100);
    wr(tsm_pkg::R_TADDR, 32'h0000_00C2);
    rd(tsm_pkg::R_TDATA, 32'h0000_0005);
    wr(tsm_pkg::R_CTRL, 32'h0000_0001);
    rd(tsm_pkg::R_STATUS, 32'h0000_0911);
    for (k = 0; k < 4; k++)
      u_tsm_far_end.drive(8'hA5, 8'h00, 4'h0, 1);
    rd(tsm_pkg::R_STATUS, 32'h0000_0511);
    for (k = 0; k < 5; k++)
      u_tsm_far_end.drive(8'hA5, 8'h00, 4'h0, 1);
    rd(tsm_pkg::R_STATUS, 32'h0000_0019);
    check(u_tsm_far_end.snaps, 32'h0000_0000);
    u_tsm_far_end.drive(8'hA5, 8'h00, 4'h0, 1);
    check(u_tsm_far_end.snaps, 32'h0000_0001);
    rd(tsm_pkg::R_STATUS, 32'h0000_001B);
    wr(tsm_pkg::R_CTRL, 32'h0000_0002);
    rd(tsm_pkg::R_STATUS, 32'h0000_001A);
    check({31'h0, run}, 32'h0000_0000);
    $display("end of test tenth occurrence");

    fill(2'd0, 2);
    wr(tsm_pkg::R_CTRL, 32'h0000_0001);
    rd(tsm_pkg::R_STATUS, 32'h0000_0009);
    for (k = 0; k < 8; k++)
    begin
      wr(tsm_pkg::R_XSEL, k);
      s0 = u_tsm_far_end.snaps;
      u_tsm_far_end.drive(8'h5A, ~(8'h01 << k), 4'h0, 3);
      check(u_tsm_far_end.snaps - s0, 32'h0000_0000);
      u_tsm_far_end.drive(8'h5A, 8'h01 << k, 4'h0, 3);
      check(u_tsm_far_end.snaps - s0, 32'h0000_0003);
    end
    wr(tsm_pkg::R_XSEL, 32'h0000_0500);
    s0 = u_tsm_far_end.snaps;
    u_tsm_far_end.drive(8'h5A, 8'h00, 4'h1, 2);
    check(u_tsm_far_end.snaps - s0, 32'h0000_0000);
    u_tsm_far_end.drive(8'h5A, 8'h00, 4'h5, 2);
    u_tsm_far_end.drive(8'h5A, 8'h00, 4'hF, 2);
    check(u_tsm_far_end.snaps - s0, 32'h0000_0004);
    $display("end of test trigger inputs");

    wr(tsm_pkg::R_CTRL, 32'h0000_0004);
    wait_clear();
    wr(tsm_pkg::R_TADDR, 32'h0000_00C2);
    rd(tsm_pkg::R_TDATA, 32'h0000_0001);
    wr(tsm_pkg::R_CTRL, 32'h0000_0001);
    s0 = u_tsm_far_end.snaps;
    u_tsm_far_end.drive(8'hA5, 8'hFF, 4'hF, 3);
    check(u_tsm_far_end.snaps - s0, 32'h0000_0000);
    rd(tsm_pkg::R_STATUS, 32'h0000_0009);
    $display("end of test cleared table");
    print_verdict();
  end
endmodule
